// ### design/dtm_defines.vh
`ifndef DTM_DEFINES_VH
`define DTM_DEFINES_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DTM_IDX_CTRL 6'h1A
`define DTM_IDX_ALT 6'h1B
`define DTM_IDX_STAT 6'h1C
`define DTM_IDX_MASK 6'h1D
`define DTM_IDX_MODE 6'h1E

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DTM_CTRL_RSVD 15
`define DTM_CTRL_POLL_HI 14
`define DTM_CTRL_POLL_LO 13
`define DTM_CTRL_THR_HI 12
`define DTM_CTRL_THR_LO 8
`define DTM_CTRL_IEN 7
`define DTM_CTRL_FLAG 6
`define DTM_CTRL_MAN 5
`define DTM_THR_RST 5'h19
`define DTM_POLL_SLOW 2'h0
`define DTM_POLL_FAST 2'h1

// ----------------------------------------------------------------
// alternative reading register fields
// ----------------------------------------------------------------
`define DTM_ALT_RSVD_HI 15
`define DTM_ALT_RSVD_LO 13
`define DTM_ALT_AVG_HI 12
`define DTM_ALT_AVG_LO 11
`define DTM_ALT_INT_HI 10
`define DTM_ALT_INT_LO 8
`define DTM_AVG_RST 2'h1
`define DTM_INT_RST 3'h4

// ----------------------------------------------------------------
// interrupt status / mask and manual mode
// ----------------------------------------------------------------
`define DTM_IRQ_OVER 0
`define DTM_IRQ_DONE 1
`define DTM_MASK_RST 2'h1
`define DTM_MODE_MANUAL 2'h2

// ----------------------------------------------------------------
// timing, in microseconds unless stated
// ----------------------------------------------------------------
`define DTM_CLK_MHZ 125
`define DTM_POLL_SLOW_US 1000000
`define DTM_POLL_FAST_US 10000
`define DTM_INT0_US 14'h001C
`define DTM_INT1_US 14'h0038
`define DTM_INT2_US 14'h00A8
`define DTM_INT3_US 14'h0118
`define DTM_INT4_US 14'h0330
`define DTM_INT5_US 14'h08E8
`define DTM_INT6_US 14'h184C
`define DTM_INT7_US 14'h2E0E
`define DTM_AVG_EXP_BASE 9

`endif

// ### design/dtm_top.v
// Functional notes
// - poll field: 1 s, 10 ms, or off
// - threshold is 5*code-25 C, resets 0x19
// - bit 7 enables over-temperature interrupt
// - bit 6 latches high at threshold
// - bit 5 drives acquire in manual mode
// - bits 4:0 return raw bits 5:1
// - averaging 2^9..2^15 samples, resets 01
// - sample interval 28 us..11.79 ms, resets 100
// - alternative reading is degrees plus 25
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`include "dtm_defines.vh"

module dtm_top #(
    parameter TICK_CYCLES = `DTM_CLK_MHZ,      // clock cycles per microsecond tick
    parameter POLL_SLOW_US = `DTM_POLL_SLOW_US, // slow poll period
    parameter POLL_FAST_US = `DTM_POLL_FAST_US, // fast poll period
    parameter AVG_EXP_BASE = `DTM_AVG_EXP_BASE  // exponent of averaging code 00
) (
    input wire CLK_SYS,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    output wire SENSE_ACQ,
    input wire SENSE_VALID,
    input wire [5:0] SENSE_RAW,
    input wire [7:0] SENSE_ALT,
    output wire IRQ
);

// ----------------------------------------------------------------
// constants
// ----------------------------------------------------------------
// two states only, so a single bit holds the sampler state
localparam ST_IDLE = 1'b0; // waiting for a poll or manual sample
localparam ST_RUN = 1'b1;  // averaging run in progress
// byte addresses; each 16-bit register sits in the low half of a word
localparam [7:0] ADDR_CTRL = {`DTM_IDX_CTRL, 2'b00};
localparam [7:0] ADDR_ALT = {`DTM_IDX_ALT, 2'b00};
localparam [7:0] ADDR_STAT = {`DTM_IDX_STAT, 2'b00};
localparam [7:0] ADDR_MASK = {`DTM_IDX_MASK, 2'b00};
localparam [7:0] ADDR_MODE = {`DTM_IDX_MODE, 2'b00};
// divider end count, one wrap per microsecond
localparam [15:0] TICK_LAST = TICK_CYCLES[15:0] - 16'h0001;

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg rsvd_q;               // reserved control bit, kept as written
reg [1:0] poll_q;         // polling control
reg [4:0] thr_q;          // threshold code
reg ien_q;                // interrupt enable
reg flag_q;               // latched threshold flag
reg man_q;                // manual acquire level
reg [4:0] coarse_q;       // coarse reading
reg [2:0] alt_rsvd_q;     // reserved bits of second register
reg [1:0] avg_q;          // averaging code
reg [2:0] int_q;          // sample interval code
reg [7:0] alt_q;          // alternative reading
reg [1:0] stat_q;         // sticky interrupt status
reg [1:0] mask_q;         // interrupt mask
reg [1:0] mode_q;         // sensor control mode, 10 = manual
reg state_q;              // sampler state
reg [15:0] tick_cnt_q;    // microsecond divider
reg [19:0] poll_cnt_q;    // poll period counter, in microseconds
reg [13:0] int_cnt_q;     // sample interval counter, in microseconds
reg [15:0] smp_cnt_q;     // samples taken in this run
reg [3:0] exp_q;          // averaging exponent latched at run start
reg [22:0] sum_alt_q;     // accumulated alternative samples
reg [20:0] sum_raw_q;     // accumulated raw samples
reg acq_q;                // automatic acquire strobe

// ----------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------
wire setup = PSEL & ~PENABLE;          // first cycle of a transfer
wire access = PSEL & PENABLE;          // completing cycle (no waits)
wire wr = access & PWRITE;
wire rd = access & ~PWRITE;
// full byte address compare, so unaligned offsets miss
wire hit_ctrl = (PADDR == ADDR_CTRL);
wire hit_alt = (PADDR == ADDR_ALT);
wire hit_stat = (PADDR == ADDR_STAT);
wire hit_mask = (PADDR == ADDR_MASK);
wire hit_mode = (PADDR == ADDR_MODE);
// any mapped register; a miss answers with an error
wire hit = hit_ctrl | hit_alt | hit_stat | hit_mask | hit_mode;
wire lo_en = wr & PSTRB[0];            // byte lane 0 write
wire hi_en = wr & PSTRB[1];            // byte lane 1 write

// the slave never stalls: every access completes in its first cycle
assign PREADY = 1'b1;
// unmapped addresses complete with an error and touch nothing
assign PSLVERR = access & ~hit;

// ----------------------------------------------------------------
// derived values
// ----------------------------------------------------------------
// manual strobe control only applies with the mode code set
wire manual = (mode_q == `DTM_MODE_MANUAL);
// alternative scale is degrees plus 25, threshold is 5*code-25 degrees,
// so reaching the threshold means reading >= 5*code
wire [7:0] thr_alt = {1'b0, thr_q, 2'b00} + {3'b000, thr_q};
wire above = (alt_q >= thr_alt);
// rate enable: one cycle in every microsecond
wire us_tick = (tick_cnt_q == TICK_LAST);
wire poll_off = poll_q[1];
// poll end count, minus one since the counter starts at zero
wire [19:0] poll_last = (poll_q[0] ? POLL_FAST_US[19:0] : POLL_SLOW_US[19:0]) - 20'h0_0001;
// run length follows the exponent latched at run start
wire [15:0] smp_target = 16'h0001 << exp_q;
// samples count only inside a run; idle answers are dropped
wire smp_take = (state_q == ST_RUN) & SENSE_VALID;
wire run_done = smp_take & (smp_cnt_q == smp_target - 16'h0001);
// a poll landing during a run is dropped, not queued
wire poll_hit = us_tick & (poll_cnt_q == poll_last) & ~poll_off & ~manual;
// a run starts on a poll in automatic mode, or on a sensor
// answer in manual mode, which serves only as the trigger
wire start = (state_q == ST_IDLE) & (poll_hit | (manual & SENSE_VALID));

// interval lookup, counts in microsecond ticks
// a table, since the interval steps follow no formula
reg [13:0] int_last;
always @* begin
    case (int_q)
        3'h0: int_last = `DTM_INT0_US - 14'h0001;
        3'h1: int_last = `DTM_INT1_US - 14'h0001;
        3'h2: int_last = `DTM_INT2_US - 14'h0001;
        3'h3: int_last = `DTM_INT3_US - 14'h0001;
        3'h4: int_last = `DTM_INT4_US - 14'h0001;
        3'h5: int_last = `DTM_INT5_US - 14'h0001;
        3'h6: int_last = `DTM_INT6_US - 14'h0001;
        default: int_last = `DTM_INT7_US - 14'h0001;
    endcase
end

// averaged values: sum shifted down by the run's exponent
wire [22:0] avg_alt_full = sum_alt_q + {15'h0000, SENSE_ALT};
wire [20:0] avg_raw_full = sum_raw_q + {15'h0000, SENSE_RAW};
// truncating shift; rounding would cost an adder per sum
wire [22:0] avg_alt_sh = avg_alt_full >> exp_q;
wire [20:0] avg_raw_sh = avg_raw_full >> exp_q;

// ----------------------------------------------------------------
// sensor strobe
// ----------------------------------------------------------------
// in manual mode the pin simply follows the control bit; the automatic
// strobe is held off so the two sources never fight
assign SENSE_ACQ = manual ? man_q : acq_q;

// ----------------------------------------------------------------
// timebase: microsecond tick and poll counter
// ----------------------------------------------------------------
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        tick_cnt_q <= 16'h0000;
        poll_cnt_q <= 20'h0_0000;
    end else begin
        // free-running divider keeps the poll phase regular
        tick_cnt_q <= us_tick ? 16'h0000 : tick_cnt_q + 16'h0001;
        // poll counter parks at zero while polling is stopped
        if (poll_off | manual) begin
            poll_cnt_q <= 20'h0_0000;
        end else if (us_tick) begin
            poll_cnt_q <= (poll_cnt_q == poll_last) ? 20'h0_0000 : poll_cnt_q + 20'h0_0001;
        end
    end
end

// ----------------------------------------------------------------
// sampler: acquire strobes, accumulation and readout update
// ----------------------------------------------------------------
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        state_q <= ST_IDLE;
        int_cnt_q <= 14'h0000;
        smp_cnt_q <= 16'h0000;
        exp_q <= 4'h0;
        sum_alt_q <= 23'h00_0000;
        sum_raw_q <= 21'h00_0000;
        acq_q <= 1'b0;
        alt_q <= 8'h00;
        coarse_q <= 5'h00;
    end else begin
        acq_q <= 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start) begin
                    // exponent frozen so a mid-run write cannot tear the average
                    exp_q <= AVG_EXP_BASE[3:0] + {1'b0, avg_q, 1'b0};
                    int_cnt_q <= 14'h0000;
                    smp_cnt_q <= 16'h0000;
                    sum_alt_q <= 23'h00_0000;
                    sum_raw_q <= 21'h00_0000;
                    acq_q <= ~manual;
                    state_q <= ST_RUN;
                end
            end
            ST_RUN: begin
                // one automatic strobe per sample interval
                if (us_tick) begin
                    if (int_cnt_q == int_last) begin
                        int_cnt_q <= 14'h0000;
                        acq_q <= ~manual;
                    end else begin
                        int_cnt_q <= int_cnt_q + 14'h0001;
                    end
                end
                if (run_done) begin
                    // readouts only move once a whole run is summed
                    alt_q <= avg_alt_sh[7:0];
                    coarse_q <= avg_raw_sh[5:1];
                    state_q <= ST_IDLE;
                end else if (smp_take) begin
                    sum_alt_q <= avg_alt_full;
                    sum_raw_q <= avg_raw_full;
                    smp_cnt_q <= smp_cnt_q + 16'h0001;
                end
            end
            // a state value matching neither code falls back to idle
            default: state_q <= ST_IDLE;
        endcase
    end
end

// ----------------------------------------------------------------
// software writable fields
// ----------------------------------------------------------------
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        rsvd_q <= 1'b0;
        poll_q <= `DTM_POLL_SLOW;
        thr_q <= `DTM_THR_RST;
        ien_q <= 1'b0;
        man_q <= 1'b0;
        alt_rsvd_q <= 3'h0;
        avg_q <= `DTM_AVG_RST;
        int_q <= `DTM_INT_RST;
        mask_q <= `DTM_MASK_RST;
        mode_q <= 2'h0;
    end else begin
        if (hit_ctrl & hi_en) begin
            // bit 15 is stored as written; software keeps it at zero
            rsvd_q <= PWDATA[`DTM_CTRL_RSVD];
            poll_q <= PWDATA[`DTM_CTRL_POLL_HI:`DTM_CTRL_POLL_LO];
            thr_q <= PWDATA[`DTM_CTRL_THR_HI:`DTM_CTRL_THR_LO];
        end
        if (hit_ctrl & lo_en) begin
            ien_q <= PWDATA[`DTM_CTRL_IEN];
            man_q <= PWDATA[`DTM_CTRL_MAN];
        end
        if (hit_alt & hi_en) begin
            alt_rsvd_q <= PWDATA[`DTM_ALT_RSVD_HI:`DTM_ALT_RSVD_LO];
            avg_q <= PWDATA[`DTM_ALT_AVG_HI:`DTM_ALT_AVG_LO];
            int_q <= PWDATA[`DTM_ALT_INT_HI:`DTM_ALT_INT_LO];
        end
        // interrupt mask, same layout as the status register
        if (hit_mask & lo_en) begin
            mask_q <= PWDATA[1:0];
        end
        // mode register; only the manual code hands the strobe to software
        if (hit_mode & lo_en) begin
            mode_q <= PWDATA[1:0];
        end
    end
end

// ----------------------------------------------------------------
// threshold flag and interrupt status
// ----------------------------------------------------------------
// a control read clears the flag once the reading is below threshold
wire rd_ctrl = rd & hit_ctrl;
// write one to clear, byte lane 0 only
wire stat_clr_over = wr & hit_stat & PSTRB[0] & PWDATA[`DTM_IRQ_OVER];
wire stat_clr_done = wr & hit_stat & PSTRB[0] & PWDATA[`DTM_IRQ_DONE];
// over-temperature event needs the flag and its enable together
wire over_evt = flag_q & ien_q;

always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        flag_q <= 1'b0;
        stat_q <= 2'h0;
    end else begin
        // latch-high: setting beats a clearing read in the same cycle
        if (above) begin
            flag_q <= 1'b1;
        end else if (rd_ctrl) begin
            flag_q <= 1'b0;
        end
        // sticky status, write one to clear, a new event wins
        if (over_evt) begin
            stat_q[`DTM_IRQ_OVER] <= 1'b1;
        end else if (stat_clr_over) begin
            stat_q[`DTM_IRQ_OVER] <= 1'b0;
        end
        if (run_done) begin
            stat_q[`DTM_IRQ_DONE] <= 1'b1;
        end else if (stat_clr_done) begin
            stat_q[`DTM_IRQ_DONE] <= 1'b0;
        end
    end
end

// level interrupt: flag with enable drives it directly, status keeps history
assign IRQ = (over_evt & mask_q[`DTM_IRQ_OVER]) | (|(stat_q & mask_q));

// ----------------------------------------------------------------
// read data, captured in the setup cycle
// ----------------------------------------------------------------
// registering in setup keeps the output off the decode path at no cost
// in wait states; the read side effect still lands on the access edge
always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
        PRDATA <= 32'h0000_0000;
    end else if (setup & ~PWRITE) begin
        if (hit_ctrl) begin
            PRDATA <= {16'h0000, rsvd_q, poll_q, thr_q, ien_q, flag_q,
                       man_q, coarse_q};
        end else if (hit_alt) begin
            PRDATA <= {16'h0000, alt_rsvd_q, avg_q, int_q, alt_q};
        end else if (hit_stat) begin
            PRDATA <= {30'h0000_0000, stat_q};
        end else if (hit_mask) begin
            PRDATA <= {30'h0000_0000, mask_q};
        end else if (hit_mode) begin
            PRDATA <= {30'h0000_0000, mode_q};
        end else begin
            PRDATA <= 32'h0000_0000;
        end
    end
end

endmodule // dtm_top

// ### bench/dtm_top_chk.sv
`timescale 1ns/1ns
// ----------------------------------------
// port-level checker for the monitor top
// ----------------------------------------
module dtm_top_chk (
    input wire CLK_SYS,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [3:0] PSTRB,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire SENSE_ACQ,
    input wire SENSE_VALID,
    input wire [5:0] SENSE_RAW,
    input wire [7:0] SENSE_ALT,
    input wire IRQ
);
    wire wr_go = PSEL && PENABLE && PWRITE; // write lands at this edge
    wire rd_go = PSEL && PENABLE && !PWRITE; // read data is taken here
    wire is_ctrl = PADDR == 8'h68;
    wire is_alt = PADDR == 8'h6C;
    wire mapped = is_ctrl || is_alt || PADDR == 8'h70 || PADDR == 8'h74 || PADDR == 8'h78;
    reg [15:0] ctrl_q; // shadow of control, read-only bits ignored
    reg [4:0] alt_q; // shadow of averaging and interval codes
    reg [1:0] mask_q;
    reg [1:0] mode_q;
    reg [7:0] last_q; // alternative reading seen at the last read
    reg seen_q; // a sample arrived since that read
    reg v1_q; // a sample arrived one edge ago
    // shadows follow the bus; lanes are always all enabled by the bench
    always @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            ctrl_q <= 16'h1900;
            alt_q <= 5'h0C;
            mask_q <= 2'h1;
            mode_q <= 2'h0;
            last_q <= 8'h00;
            seen_q <= 1'b0;
            v1_q <= 1'b0;
        end else begin
            v1_q <= SENSE_VALID;
            if (wr_go && is_ctrl) ctrl_q <= PWDATA[15:0];
            if (wr_go && is_alt) alt_q <= PWDATA[12:8];
            if (wr_go && PADDR == 8'h74) mask_q <= PWDATA[1:0];
            if (wr_go && PADDR == 8'h78) mode_q <= PWDATA[1:0];
            // a sample at the setup edge is not yet in the data read
            if (rd_go && is_alt) begin
                last_q <= PRDATA[7:0];
                seen_q <= SENSE_VALID || v1_q;
            end else if (SENSE_VALID) begin
                seen_q <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_upper; rd_go |-> PRDATA[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read half not zero");
    property p_ctrl; rd_go && is_ctrl |-> PRDATA[15:7] == ctrl_q[15:7] && PRDATA[5] == ctrl_q[5];
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("control field lost");
    property p_alt; rd_go && is_alt |-> PRDATA[12:8] == alt_q; endproperty
    a_alt: assert property (p_alt) else $error("averaging or interval code lost");
    property p_err; PSEL && PENABLE |-> PSLVERR == !mapped; endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_man; mode_q == 2'h2 && $stable(ctrl_q[5]) && $stable(mode_q)
        |-> SENSE_ACQ == ctrl_q[5]; endproperty
    a_man: assert property (p_man) else $error("manual strobe not following bit");
    property p_pulse; $rose(SENSE_ACQ) && mode_q != 2'h2 |=> !SENSE_ACQ || mode_q == 2'h2;
    endproperty
    a_pulse: assert property (p_pulse) else $error("auto strobe wider than a cycle");
    property p_hold; rd_go && is_alt && !seen_q |-> PRDATA[7:0] == last_q; endproperty
    a_hold: assert property (p_hold) else $error("reading moved without samples");
    property p_mask; mask_q == 2'h0 |-> !IRQ; endproperty
    a_mask: assert property (p_mask) else $error("interrupt with all masked");
    property p_ien; $rose(IRQ) && mask_q == 2'h1 && $stable(mask_q) |-> ctrl_q[7]; endproperty
    a_ien: assert property (p_ien) else $error("interrupt while disabled");
    c_irq: cover property ($rose(IRQ));
    c_man: cover property (mode_q == 2'h2 && SENSE_ACQ);
    c_bad: cover property (PSEL && PENABLE && !mapped);
endmodule // dtm_top_chk

bind dtm_top dtm_top_chk u_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SENSE_ACQ(SENSE_ACQ),
    .SENSE_VALID(SENSE_VALID), .SENSE_RAW(SENSE_RAW), .SENSE_ALT(SENSE_ALT), .IRQ(IRQ));

// ### bench/dtm_sensor_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// sensor model: answers each strobe lag plus one cycles after it is seen
// ----------------------------------------
module dtm_sensor_model (
    input wire clk,
    input wire rst,
    input wire acq,
    input wire [3:0] lag,
    input wire [7:0] alt_val,
    input wire [5:0] raw_val,
    output reg valid,
    output reg [5:0] raw,
    output reg [7:0] alt
);
    reg acq_q; // strobe seen last cycle
    reg [4:0] cnt_q; // cycles left to answer, 0 when idle
    // data lines toggle outside the answer cycle so nothing stale passes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            acq_q <= 1'b0;
            cnt_q <= 5'h00;
            valid <= 1'b0;
            raw <= 6'h00;
            alt <= 8'h00;
        end else begin
            acq_q <= acq;
            valid <= 1'b0;
            raw <= ~raw;
            alt <= ~alt;
            if (acq && !acq_q) cnt_q <= {1'b0, lag} + 5'h01;
            else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
                valid <= 1'b1;
                raw <= raw_val;
                alt <= alt_val;
            end
        end
    end
endmodule // dtm_sensor_model

// ### bench/die_temperature_monitor_test.sv
`timescale 1ns/1ns
module die_temperature_monitor_test;
    localparam [7:0] A_CTRL = 8'h68;
    localparam [7:0] A_ALT = 8'h6C;
    localparam [7:0] A_STAT = 8'h70;
    localparam [7:0] A_MASK = 8'h74;
    localparam [7:0] A_MODE = 8'h78;
    reg CLK_SYS = 1'b0;
    reg RST = 1'b1;
    reg PSEL = 1'b0;
    reg PENABLE = 1'b0;
    reg PWRITE = 1'b0;
    reg [7:0] PADDR = 8'h00;
    reg [31:0] PWDATA = 32'h0000_0000;
    reg [3:0] PSTRB = 4'hF; // all lanes, the only tied input
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, SENSE_ACQ, SENSE_VALID, IRQ;
    wire [5:0] SENSE_RAW;
    wire [7:0] SENSE_ALT;
    reg [3:0] lag = 4'h1; // sensor answer delay
    reg [7:0] alt_val = 8'h7D; // 100 C, exactly the reset threshold
    reg [5:0] raw_val = 6'h2B;
    integer failures = 0;
    integer checked = 0;
    integer cyc = 0;
    integer n;
    reg [31:0] got;
    reg err;
    always #4 CLK_SYS = ~CLK_SYS;
    // hang guard, far above the several hundred cycles the tests need
    always @(posedge CLK_SYS) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            failures = failures + 1;
            summarize;
        end
    end
    dtm_top #(.TICK_CYCLES(1), .POLL_SLOW_US(50), .POLL_FAST_US(20), .AVG_EXP_BASE(1)) DUT (
        .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SENSE_ACQ(SENSE_ACQ), .SENSE_VALID(SENSE_VALID),
        .SENSE_RAW(SENSE_RAW), .SENSE_ALT(SENSE_ALT), .IRQ(IRQ));
    dtm_sensor_model u_sensor (.clk(CLK_SYS), .rst(RST), .acq(SENSE_ACQ), .lag(lag),
        .alt_val(alt_val), .raw_val(raw_val), .valid(SENSE_VALID), .raw(SENSE_RAW),
        .alt(SENSE_ALT));
    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", checked, failures);
            if (failures == 0 && checked > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task cmp(input [31:0] g, input [31:0] e);
        begin
            checked = checked + 1;
            if (g !== e) begin
                failures = failures + 1;
                $display("unexpected at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge CLK_SYS);
            PSEL <= 1'b1;
            PWRITE <= w;
            PADDR <= a;
            PWDATA <= d;
            @(posedge CLK_SYS);
            PENABLE <= 1'b1;
            @(posedge CLK_SYS);
            while (PREADY !== 1'b1) @(posedge CLK_SYS);
            got = PRDATA;
            err = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            apb(1'b1, a, d);
            cmp({31'h0, err}, 32'h0);
        end
    endtask
    task rd(input [7:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            cmp(got, e);
            cmp({31'h0, err}, 32'h0);
        end
    endtask
    task till(input e);
        for (n = 0; n < 4000 && IRQ !== e; n = n + 1) @(negedge CLK_SYS);
    endtask
    // clear the done bit, then poll until a fresh run completes
    task run_done;
        begin
            wr(A_STAT, 32'h0000_0002);
            got = 32'h0;
            for (n = 0; n < 200 && got[1] !== 1'b1; n = n + 1) apb(1'b0, A_STAT, 32'h0);
        end
    endtask
    initial begin
        repeat (16) @(posedge CLK_SYS);
        RST <= 1'b0;
        wr(A_CTRL, 32'h0000_5900);
        rd(A_CTRL, 32'h0000_5900);
        rd(A_ALT, 32'h0000_0C00);
        rd(A_STAT, 32'h0000_0000);
        rd(A_MASK, 32'h0000_0001);
        rd(A_MODE, 32'h0000_0000);
        apb(1'b0, 8'h7C, 32'h0);
        cmp(got, 32'h0000_0000);
        cmp({31'h0, err}, 32'h0000_0001);
        $display("test reset_values done");
        wr(A_ALT, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_3980);
        till(1'b1);
        cmp({31'h0, IRQ}, 32'h0000_0001);
        rd(A_ALT, 32'h0000_007D);
        rd(A_CTRL, 32'h0000_39D5);
        $display("test threshold_hit done");
        lag <= 4'h9;
        alt_val <= 8'h7C;
        raw_val <= 6'h20;
        run_done;
        run_done;
        rd(A_ALT, 32'h0000_007C);
        rd(A_CTRL, 32'h0000_39D0);
        rd(A_CTRL, 32'h0000_3990);
        wr(A_STAT, 32'h0000_0001);
        @(negedge CLK_SYS);
        cmp({31'h0, IRQ}, 32'h0000_0000);
        $display("test flag_clear done");
        lag <= 4'h1;
        alt_val <= 8'h90;
        till(1'b1);
        wr(A_MASK, 32'h0000_0000);
        @(negedge CLK_SYS);
        cmp({31'h0, IRQ}, 32'h0000_0000);
        wr(A_CTRL, 32'h0000_3900);
        wr(A_STAT, 32'h0000_0003);
        wr(A_MASK, 32'h0000_0001);
        @(negedge CLK_SYS);
        cmp({31'h0, IRQ}, 32'h0000_0000);
        wr(A_MASK, 32'h0000_0002);
        till(1'b1);
        cmp({31'h0, IRQ}, 32'h0000_0001);
        $display("test masking done");
        wr(A_CTRL, 32'h0000_5900);
        repeat (100) @(negedge CLK_SYS);
        got = 32'h0;
        repeat (200) begin
            @(negedge CLK_SYS);
            if (SENSE_ACQ === 1'b1) got = got + 32'h1;
        end
        cmp(got, 32'h0000_0000);
        wr(A_MODE, 32'h0000_0002);
        wr(A_CTRL, 32'h0000_5920);
        repeat (2) @(negedge CLK_SYS);
        cmp({31'h0, SENSE_ACQ}, 32'h0000_0001);
        wr(A_CTRL, 32'h0000_5900);
        repeat (2) @(negedge CLK_SYS);
        cmp({31'h0, SENSE_ACQ}, 32'h0000_0000);
        $display("test manual done");
        summarize;
    end
endmodule // die_temperature_monitor_test
